// ---- src/qps_top.sv ----
// Command logic for four-lane page program and program/erase suspend.
// Assumes a host driving chip select and serial clock, and array logic on
// the core clock that runs programs and erases and reports busy.
//
// Behaviour
// RULE1: host sets latch and four-lane permit first
// RULE2: opcode 32h, lane 0, eight clocks, MSB first
// RULE3: 24-bit address on lane 0, A23 first
// RULE4: lane 1 output released after last address bit
// RULE5: byte per two clocks, high nibble first
// RULE6: buffer keeps latest 256 bytes only
// RULE7: chip select off mid-byte aborts program
// RULE8: protected target: no program, back to idle
// RULE9: data past page end wraps within page
// RULE10: incomplete address or data clears write latch
// RULE11: opcodes 75h and B0h suspend identically
// RULE12: suspend is one opcode, no address or data
// RULE13: suspend starts at chip select release
// RULE14: disallowed command ignored, write latch kept
// RULE15: busy and paused states shown by status bits
// RULE16: reads refused busy, allowed when suspended
// RULE17: erases refused busy and in either suspend
// RULE18: programs allowed only during erase suspend
// RULE19: suspend acted on only while busy
// RULE20: program in erase suspend needs other block
// RULE21: suspending sets paused bits, clears in-progress
// RULE22: status and one-time writes not suspendable
// RULE23: lanes sampled on rising serial clock
`timescale 1ns/1ps
`include "qps_regs.svh"
module qps_top (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        LINK_SCK_I,
  input  wire logic        CS_N_I,
  input  wire logic [3:0]  LANE_I,
  output logic             LANE1_O,
  output logic             LANE1_OE_O,
  input  wire logic        WRITE_LATCH_FLAG_I,
  input  wire logic        FOUR_LANE_PERMIT_I,
  input  wire logic        PROTECTED_I,
  input  wire logic        OP_BUSY_I,
  input  wire logic        OP_IS_ERASE_I,
  input  wire logic        OP_SUSPENDABLE_I,
  input  wire logic [7:0]  OP_BLOCK_I,
  input  wire logic        RESUME_I,
  input  wire logic [7:0]  BUF_RADDR_I,
  output logic [7:0]       BUF_RDATA_O,
  output logic [23:0]      TARGET_ADDR_O,
  output logic [8:0]       PROG_COUNT_O,
  output logic             PROG_START_O,
  output logic             WRITE_LATCH_CLR_O,
  output logic             SUSPEND_REQ_O,
  output logic             CMD_VALID_O,
  output logic             CMD_REJECT_O,
  output logic [7:0]       CMD_OPCODE_O,
  output logic             OP_IN_PROGRESS_O,
  output logic             PAUSED_FLAG_O,
  output logic             PROGRAM_PAUSED_O,
  output logic             ERASE_PAUSED_O
);
  // --------------------------------------------------------------------
  // Link side: frame shifter on the serial clock
  // --------------------------------------------------------------------
  logic        in_frame_q;
  logic        oe_q;
  logic        so_q;
  logic [5:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [3:0]  nib_q;
  logic        half_q;
  logic [8:0]  bytes_q;
  logic [7:0]  wptr_q;
  logic [7:0]  buf_q [256];

  wire         first    = ~in_frame_q;
  wire  [5:0]  cnt_cur  = first ? 6'h00 : cnt_q;
  wire  [7:0]  sh_base  = first ? 8'h00 : sh_q;
  wire  [7:0]  sh_d     = {sh_base[6:0], LANE_I[0]};
  wire         cap_op   = (cnt_cur == `QPS_OPC_LAST);
  wire         addr_ph  = (cnt_cur >= `QPS_CMD_CLKS) &&
                          (cnt_cur < `QPS_HDR_CLKS);
  wire         addr_end = (cnt_cur == `QPS_ADR_LAST) &&
                          (op_q == `QPS_OP_Q4PROG);
  wire         data_ph  = (cnt_cur == `QPS_HDR_CLKS) &&
                          (op_q == `QPS_OP_Q4PROG);
  wire         wr_byte  = data_ph & half_q;
  wire  [5:0]  cnt_d    = (cnt_cur == `QPS_HDR_CLKS) ? cnt_cur
                                                     : cnt_cur + 6'h01;
  wire         half_d   = first ? 1'b0 : (data_ph ? ~half_q : half_q);
  wire  [8:0]  bytes_b  = first ? 9'h000 : bytes_q;
  wire         bytes_up = wr_byte && (bytes_b != `QPS_PAGE_BYTES);
  wire         oe_d     = first ? 1'b1 : (addr_end ? 1'b0 : oe_q);

  // Chip select high releases lane 1 and marks the next edge as first
  always_ff @(posedge LINK_SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      in_frame_q <= 1'b0;
      oe_q       <= 1'b0;
      so_q       <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
      oe_q       <= oe_d;                                 // see RULE4
      so_q       <= 1'b0;
    end
  end

  always_ff @(posedge LINK_SCK_I) begin                   // see RULE23
    cnt_q  <= cnt_d;
    sh_q   <= sh_d;                                       // see RULE2
    half_q <= half_d;
    if (cap_op) begin
      op_q <= sh_d;                                       // see RULE2
    end
    if (addr_ph) begin
      addr_q <= {addr_q[22:0], LANE_I[0]};                // see RULE3
    end
    if (addr_end) begin
      wptr_q <= {addr_q[6:0], LANE_I[0]};
    end else if (wr_byte) begin
      wptr_q <= wptr_q + 8'h01;                           // see RULE9
    end
    if (data_ph && !half_q) begin
      nib_q <= LANE_I;                                    // see RULE5
    end
    if (wr_byte) begin
      buf_q[wptr_q] <= {nib_q, LANE_I};                   // see RULE6
    end
    bytes_q <= bytes_up ? bytes_b + 9'h001 : bytes_b;
  end

  assign LANE1_O    = so_q;
  assign LANE1_OE_O = oe_q;

  // --------------------------------------------------------------------
  // Core side: frame end detection and capture
  // --------------------------------------------------------------------
  logic                cs1_q;
  logic                cs2_q;
  logic                cs3_q;
  logic                eval_q;
  qps_pkg::qps_frame_t fr_q;
  logic [7:0]          rdata_q;

  wire cs_rise = cs2_q & ~cs3_q;

  // Link registers hold still while chip select is high
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      cs1_q  <= 1'b1;
      cs2_q  <= 1'b1;
      cs3_q  <= 1'b1;
      eval_q <= 1'b0;
      fr_q   <= '0;
    end else begin
      cs1_q  <= CS_N_I;
      cs2_q  <= cs1_q;
      cs3_q  <= cs2_q;
      eval_q <= cs_rise;
      if (cs_rise) begin
        fr_q <= '{opcode: op_q, addr: addr_q, clks: cnt_q,
                  half: half_q, bytes: bytes_q};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    rdata_q <= buf_q[BUF_RADDR_I];
  end

  // --------------------------------------------------------------------
  // Core side: command classes and permission
  // --------------------------------------------------------------------
  qps_pkg::qps_state_t st_q;
  qps_pkg::qps_state_t st_d;
  logic                erase_q;
  logic                paused_flag_ok_q;
  logic [7:0]          blk_q;

  wire [7:0] opc      = fr_q.opcode;
  wire       opv      = fr_q.clks >= `QPS_CMD_CLKS;
  wire       whole    = opv && (fr_q.clks[2:0] == 3'h0) && !fr_q.half;
  wire       is_read  = opv && (opc inside {`QPS_OP_RD_A, `QPS_OP_RD_B,
                         `QPS_OP_RD_C, `QPS_OP_RD_D, `QPS_OP_RD_E,
                         `QPS_OP_RD_F});
  wire       is_erase = opv && (opc inside {`QPS_OP_ER_A, `QPS_OP_ER_B,
                         `QPS_OP_ER_C, `QPS_OP_ER_D, `QPS_OP_ER_E});
  wire       is_q4    = opv && (opc == `QPS_OP_Q4PROG);
  wire       is_prog  = is_q4 || (opv && (opc inside {`QPS_OP_PG_A,
                         `QPS_OP_PG_B, `QPS_OP_PG_C, `QPS_OP_PG_D}));
  wire       is_paused_flag  = opv && (opc inside {`QPS_OP_PAUSED_FLAG_A,
                         `QPS_OP_PAUSED_FLAG_B});                // see RULE11
  wire       busy     = (st_q == qps_pkg::QPS_BUSY);
  wire       idle     = (st_q == qps_pkg::QPS_IDLE);
  wire       esusp    = (st_q == qps_pkg::QPS_ESUSP);
  wire       same_blk = (fr_q.addr[23:16] == blk_q);
  wire       ok_read  = !busy;                            // see RULE16
  wire       ok_erase = idle;                             // see RULE17
  wire       ok_prog  = idle || (esusp && !same_blk);     // see RULE18
  wire       ok_paused_flag  = busy && paused_flag_ok_q;                // see RULE19
  wire       allowed  = is_read  ? ok_read  :
                        is_erase ? ok_erase :
                        is_prog  ? ok_prog  :
                        is_paused_flag  ? ok_paused_flag  : 1'b1;
  wire       known    = is_read | is_erase | is_prog | is_paused_flag;
  wire       q4_full  = (fr_q.clks == `QPS_HDR_CLKS) && !fr_q.half;
  wire       q4_done  = is_q4 && q4_full && (fr_q.bytes != 9'h000);
  wire       q4_short = is_q4 && !q4_full;                // see RULE7
  wire       prereq   = WRITE_LATCH_FLAG_I && FOUR_LANE_PERMIT_I;
  wire       paused_flag_go  = eval_q && is_paused_flag && ok_paused_flag &&
                        (fr_q.clks == `QPS_CMD_CLKS);     // see RULE12
  wire       q4_go    = eval_q && q4_done && ok_prog && prereq &&
                        !PROTECTED_I;                     // see RULE1
  wire       wel_clr  = eval_q && is_q4 && ok_prog &&
                        (q4_short || (q4_done && PROTECTED_I));
  wire       reject   = eval_q && known && !allowed;      // see RULE14
  wire       fwd      = eval_q && whole && allowed && !is_q4 && !is_paused_flag;

  // --------------------------------------------------------------------
  // Core side: operation state
  // --------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      qps_pkg::QPS_IDLE: begin
        if (OP_BUSY_I) begin
          st_d = qps_pkg::QPS_BUSY;
        end
      end
      qps_pkg::QPS_BUSY: begin
        if (paused_flag_go) begin                                // see RULE13
          st_d = erase_q ? qps_pkg::QPS_ESUSP : qps_pkg::QPS_PSUSP;
        end else if (!OP_BUSY_I) begin
          st_d = qps_pkg::QPS_IDLE;
        end
      end
      qps_pkg::QPS_PSUSP, qps_pkg::QPS_ESUSP: begin
        if (RESUME_I) begin
          st_d = qps_pkg::QPS_BUSY;
        end
      end
      default: begin
        st_d = qps_pkg::QPS_IDLE;
      end
    endcase
  end

  logic prog_q, wclr_q, paused_flag_q, valid_q, rej_q;
  logic opip_q, paused_q, ppause_q, epause_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      st_q      <= qps_pkg::QPS_IDLE;
      erase_q   <= 1'b0;
      paused_flag_ok_q <= 1'b0;
      blk_q     <= 8'h00;
      prog_q    <= 1'b0;
      wclr_q    <= 1'b0;
      paused_flag_q    <= 1'b0;
      valid_q   <= 1'b0;
      rej_q     <= 1'b0;
      opip_q    <= 1'b0;
      paused_q  <= 1'b0;
      ppause_q  <= 1'b0;
      epause_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (idle && OP_BUSY_I) begin
        erase_q   <= OP_IS_ERASE_I;
        paused_flag_ok_q <= OP_SUSPENDABLE_I;                    // see RULE22
        blk_q     <= OP_BLOCK_I;                          // see RULE20
      end
      prog_q   <= q4_go;                                  // see RULE8
      wclr_q   <= wel_clr;                                // see RULE10
      paused_flag_q   <= paused_flag_go;
      valid_q  <= fwd;
      rej_q    <= reject;
      opip_q   <= (st_d == qps_pkg::QPS_BUSY);            // see RULE15
      paused_q <= (st_d == qps_pkg::QPS_PSUSP) ||
                  (st_d == qps_pkg::QPS_ESUSP);           // see RULE21
      ppause_q <= (st_d == qps_pkg::QPS_PSUSP);
      epause_q <= (st_d == qps_pkg::QPS_ESUSP);
    end
  end

  assign BUF_RDATA_O       = rdata_q;
  assign TARGET_ADDR_O     = fr_q.addr;
  assign PROG_COUNT_O      = fr_q.bytes;
  assign CMD_OPCODE_O      = fr_q.opcode;
  assign PROG_START_O      = prog_q;
  assign WRITE_LATCH_CLR_O = wclr_q;
  assign SUSPEND_REQ_O     = paused_flag_q;
  assign CMD_VALID_O       = valid_q;
  assign CMD_REJECT_O      = rej_q;
  assign OP_IN_PROGRESS_O  = opip_q;
  assign PAUSED_FLAG_O     = paused_q;
  assign PROGRAM_PAUSED_O  = ppause_q;
  assign ERASE_PAUSED_O    = epause_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_oe_release;
    @(posedge LINK_SCK_I) disable iff (CS_N_I)
      (in_frame_q && cnt_q == `QPS_ADR_LAST && op_q == `QPS_OP_Q4PROG)
        |=> !oe_q;
  endproperty
  a_oe_release: assert property (p_oe_release)            // see RULE4
    else $error("lane 1 still driven after address");
  property p_wrap;
    @(posedge LINK_SCK_I) disable iff (CS_N_I)
      wr_byte |=> (wptr_q == $past(wptr_q) + 8'h01);
  endproperty
  a_wrap: assert property (p_wrap)                        // see RULE9
    else $error("write pointer did not wrap in page");
  property p_start_whole;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      $rose(prog_q) |-> fr_q.clks == 6'h20 && !fr_q.half &&
                        $past(!PROTECTED_I);
  endproperty
  a_start_whole: assert property (p_start_whole)          // see RULE7
    else $error("program started from partial or protected frame");
  property p_short_clr;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (eval_q && is_q4 && ok_prog && fr_q.clks < 6'h20) |=>
        wclr_q && !prog_q;
  endproperty
  a_short_clr: assert property (p_short_clr)              // see RULE10
    else $error("short address did not clear write latch");
  property p_rej_keep;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      rej_q |-> !wclr_q && !prog_q && !paused_flag_q && !valid_q;
  endproperty
  a_rej_keep: assert property (p_rej_keep)                // see RULE14
    else $error("refused command had an effect");
  property p_status;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      opip_q |-> !ppause_q && !epause_q && !paused_q;
  endproperty
  a_status: assert property (p_status)                    // see RULE15
    else $error("in-progress and paused shown together");
  property p_read_ok;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (eval_q && is_read && whole && !busy) |=> valid_q ##1 !valid_q;
  endproperty
  a_read_ok: assert property (p_read_ok)                  // see RULE16
    else $error("read refused while suspended");
  property p_erase_no;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (eval_q && is_erase && !idle) |=> rej_q && !valid_q;
  endproperty
  a_erase_no: assert property (p_erase_no)                // see RULE17
    else $error("erase accepted while busy or suspended");
  property p_prog_blk;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      $rose(prog_q) |-> $past(idle || (esusp && !same_blk));
  endproperty
  a_prog_blk: assert property (p_prog_blk)                // see RULE20
    else $error("program started in suspended block");
  property p_paused_flag;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (eval_q && is_paused_flag && busy && paused_flag_ok_q && fr_q.clks == 6'h08)
        |=> paused_flag_q && paused_q && !opip_q && (ppause_q != epause_q);
  endproperty
  a_paused_flag: assert property (p_paused_flag)                        // see RULE21
    else $error("suspend did not pause the operation");
  property p_paused_flag_busy;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      paused_flag_q |-> $past(busy, 2) || $past(opip_q);
  endproperty
  a_paused_flag_busy: assert property (p_paused_flag_busy)              // see RULE19
    else $error("suspend acted on while not busy");
  c_paused_flag:  cover property (@(posedge CORE_CLK_I) paused_flag_q);
  c_prog:  cover property (@(posedge CORE_CLK_I) prog_q && epause_q);
  c_rej:   cover property (@(posedge CORE_CLK_I) rej_q && paused_q);
  c_clr:   cover property (@(posedge CORE_CLK_I) wclr_q);
endmodule : qps_top

// ---- src/qps_regs.svh ----
// Opcodes, field limits and counts for the four-lane program and suspend
// logic. Assumes inclusion by qps_top only.
`ifndef QPS_REGS_SVH
`define QPS_REGS_SVH
// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define QPS_OP_Q4PROG   8'h32
`define QPS_OP_PAUSED_FLAG_A   8'h75
`define QPS_OP_PAUSED_FLAG_B   8'hB0
`define QPS_OP_RD_A     8'h03
`define QPS_OP_RD_B     8'h0B
`define QPS_OP_RD_C     8'h3B
`define QPS_OP_RD_D     8'h6B
`define QPS_OP_RD_E     8'hEB
`define QPS_OP_RD_F     8'hE7
`define QPS_OP_ER_A     8'h20
`define QPS_OP_ER_B     8'h52
`define QPS_OP_ER_C     8'hD8
`define QPS_OP_ER_D     8'h60
`define QPS_OP_ER_E     8'hC7
`define QPS_OP_PG_A     8'h02
`define QPS_OP_PG_B     8'hA2
`define QPS_OP_PG_C     8'hAD
`define QPS_OP_PG_D     8'hAF
// ----------------------------------------------------------------------
// Frame counts in serial clocks, page size in bytes
// ----------------------------------------------------------------------
`define QPS_OPC_LAST    6'h07
`define QPS_CMD_CLKS    6'h08
`define QPS_ADR_LAST    6'h1F
`define QPS_HDR_CLKS    6'h20
`define QPS_PAGE_BYTES  9'h100
`endif

// ---- src/qps_pkg.sv ----
// Types shared by the four-lane program and suspend logic.
// Assumes the opcode header is included by the user of the types.
package qps_pkg;
  // --------------------------------------------------------------------
  // Operation state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    QPS_IDLE  = 2'b00,
    QPS_BUSY  = 2'b01,
    QPS_PSUSP = 2'b10,
    QPS_ESUSP = 2'b11
  } qps_state_t;
  // --------------------------------------------------------------------
  // Finished frame as seen by the core
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [5:0]  clks;
    logic        half;
    logic [8:0]  bytes;
  } qps_frame_t;
endpackage : qps_pkg

// ---- sim/qps_host_model.sv ----
// Host side of the serial link: chip select, serial clock and four lanes.
// Assumes the bench calls send between frames and nothing else drives them.
`timescale 1ns/1ps
module qps_host_model (
  output logic       CS_N_O,
  output logic       SCK_O,
  output logic [3:0] LANE_O,
  input  wire logic  LANE1_OE_I,
  output logic       OE_FIRST_O,
  output logic       OE_DATA_O
);
  // ----------------------------------------------------------------------
  // Idle levels; clock stands still outside frames
  // ----------------------------------------------------------------------
  initial begin
    CS_N_O     = 1'b1;
    SCK_O      = 1'b0;
    LANE_O     = 4'h0;
    OE_FIRST_O = 1'b0;
    OE_DATA_O  = 1'b0;
  end
  // ----------------------------------------------------------------------
  // Data pattern, distinct across wraps of the page
  // ----------------------------------------------------------------------
  function automatic logic [7:0] data_byte(input int i);
    return 8'(i + (i >> 8) * 17) ^ 8'h5A;
  endfunction : data_byte
  // ----------------------------------------------------------------------
  // One frame: hdr clocks on lane 0, then nib data clocks on four lanes
  // ----------------------------------------------------------------------
  task automatic send(input logic [7:0] op, input logic [23:0] adr,
                      input int hdr, input int nib);
    logic [31:0] h;
    logic [7:0]  b;
    h = {op, adr};
    LANE_O = ~LANE_O;
    CS_N_O = 1'b0;
    #40;
    for (int k = 0; k < hdr + nib; k++) begin
      if (k < hdr) begin
        LANE_O = {~LANE_O[3:1], h[31-k]};
      end else begin
        b = data_byte((k - hdr) / 2);
        LANE_O = ((k - hdr) % 2 == 0) ? b[7:4] : b[3:0];
      end
      #40 SCK_O = 1'b1;
      #40 SCK_O = 1'b0;
      if (k == 0) OE_FIRST_O = LANE1_OE_I;
      if (k == hdr) OE_DATA_O = LANE1_OE_I;
    end
    #40 CS_N_O = 1'b1;
    LANE_O = ~LANE_O;
  endtask : send
endmodule : qps_host_model

// ---- sim/qps_top_test.sv ----
// Self-checking bench for the four-lane program and suspend logic.
// Assumes the host model above and the design top qps_top.
`timescale 1ns/1ps
module qps_top_test;
  logic        CORE_CLK_I = 1'b0;
  logic        RESET_I = 1'b1;
  logic        WRITE_LATCH_FLAG_I = 1'b1;
  logic        FOUR_LANE_PERMIT_I = 1'b1;
  logic        PROTECTED_I = 1'b0;
  logic        OP_BUSY_I = 1'b0;
  logic        OP_IS_ERASE_I = 1'b0;
  logic        OP_SUSPENDABLE_I = 1'b0;
  logic [7:0]  OP_BLOCK_I = 8'h00;
  logic        RESUME_I = 1'b0;
  logic [7:0]  BUF_RADDR_I = 8'h00;
  logic        cs_n, sck, l1_o, l1_oe, oe_first, oe_data;
  logic [3:0]  lane_h;
  wire  [3:0]  lane_w = {lane_h[3:2], l1_oe ? l1_o : lane_h[1], lane_h[0]};
  logic [7:0]  buf_rdata, cmd_opcode;
  logic [23:0] target_addr;
  logic [8:0]  prog_count;
  logic        p_start, p_clr, p_paused_flag, p_valid, p_rej;
  logic        st_busy, st_paused, st_ppaused, st_epaused;
  logic [4:0]  seen = 5'h00;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // ----------------------------------------------------------------------
  // Clocks, design and host
  // ----------------------------------------------------------------------
  initial forever #50 CORE_CLK_I = ~CORE_CLK_I;
  qps_host_model qps_host_model_i (.CS_N_O(cs_n), .SCK_O(sck),
    .LANE_O(lane_h), .LANE1_OE_I(l1_oe), .OE_FIRST_O(oe_first),
    .OE_DATA_O(oe_data));
  qps_top qps_top_i (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
    .LINK_SCK_I(sck), .CS_N_I(cs_n), .LANE_I(lane_w), .LANE1_O(l1_o),
    .LANE1_OE_O(l1_oe), .WRITE_LATCH_FLAG_I(WRITE_LATCH_FLAG_I),
    .FOUR_LANE_PERMIT_I(FOUR_LANE_PERMIT_I), .PROTECTED_I(PROTECTED_I),
    .OP_BUSY_I(OP_BUSY_I), .OP_IS_ERASE_I(OP_IS_ERASE_I),
    .OP_SUSPENDABLE_I(OP_SUSPENDABLE_I), .OP_BLOCK_I(OP_BLOCK_I),
    .RESUME_I(RESUME_I), .BUF_RADDR_I(BUF_RADDR_I),
    .BUF_RDATA_O(buf_rdata), .TARGET_ADDR_O(target_addr),
    .PROG_COUNT_O(prog_count), .PROG_START_O(p_start),
    .WRITE_LATCH_CLR_O(p_clr), .SUSPEND_REQ_O(p_paused_flag),
    .CMD_VALID_O(p_valid), .CMD_REJECT_O(p_rej), .CMD_OPCODE_O(cmd_opcode),
    .OP_IN_PROGRESS_O(st_busy), .PAUSED_FLAG_O(st_paused),
    .PROGRAM_PAUSED_O(st_ppaused), .ERASE_PAUSED_O(st_epaused));
  always @(posedge CORE_CLK_I) begin
    seen <= seen | {p_start, p_clr, p_paused_flag, p_valid, p_rej};
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  // Pulses seen after one frame: {start, clear, suspend, valid, reject}
  task automatic fr(input logic [7:0] op, input logic [23:0] adr,
                    input int hdr, input int nib, input logic [4:0] exp,
                    input logic [4:0] msk);
    @(negedge CORE_CLK_I);
    seen = 5'h00;
    qps_host_model_i.send(op, adr, hdr, nib);
    repeat (10) @(posedge CORE_CLK_I);
    #1;
    chk(24'(seen & msk), 24'(exp & msk));
    if (hdr >= 8) chk(24'(cmd_opcode), 24'(op));
  endtask : fr
  task automatic st(input logic [3:0] exp);
    chk(24'({st_busy, st_paused, st_ppaused, st_epaused}), 24'(exp));
  endtask : st
  task automatic rd_buf(input logic [7:0] a, input int idx);
    @(posedge CORE_CLK_I);
    BUF_RADDR_I <= a;
    repeat (2) @(posedge CORE_CLK_I);
    #1;
    chk(24'(buf_rdata), 24'(qps_host_model_i.data_byte(idx)));
  endtask : rd_buf
  task automatic opset(input logic bsy, input logic er, input logic sp);
    @(posedge CORE_CLK_I);
    OP_BUSY_I <= bsy;
    OP_IS_ERASE_I <= er;
    OP_SUSPENDABLE_I <= sp;
    OP_BLOCK_I <= 8'h12;
    repeat (3) @(posedge CORE_CLK_I);
    #1;
  endtask : opset
  task automatic resume();
    @(posedge CORE_CLK_I);
    RESUME_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RESUME_I <= 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    #1;
  endtask : resume
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  logic [7:0] busy_ops [6] = '{8'h03, 8'hEB, 8'hD8, 8'hC7, 8'h02, 8'hAD};
  initial begin
    repeat (8) @(posedge CORE_CLK_I);
    RESET_I <= 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    fr(8'h32, 24'h0000FE, 32, 6, 5'h10, 5'h1F);
    chk(target_addr, 24'h0000FE);
    chk(24'(prog_count), 24'h000003);
    chk(24'({oe_first, oe_data}), 24'h000002);
    chk(24'(l1_o), 24'h000000);
    rd_buf(8'hFE, 0);
    rd_buf(8'hFF, 1);
    rd_buf(8'h00, 2);
    fr(8'h32, 24'h000010, 32, 600, 5'h10, 5'h1F);
    chk(24'(prog_count), 24'h000100);
    rd_buf(8'h10, 256);
    rd_buf(8'h3B, 299);
    rd_buf(8'h3C, 44);
    fr(8'h32, 24'h000000, 32, 5, 5'h08, 5'h1F);
    fr(8'h32, 24'h000000, 20, 0, 5'h08, 5'h1F);
    @(posedge CORE_CLK_I);
    PROTECTED_I <= 1'b1;
    fr(8'h32, 24'h000000, 32, 2, 5'h08, 5'h1F);
    @(posedge CORE_CLK_I);
    PROTECTED_I <= 1'b0;
    FOUR_LANE_PERMIT_I <= 1'b0;
    fr(8'h32, 24'h000000, 32, 2, 5'h00, 5'h1F);
    @(posedge CORE_CLK_I);
    FOUR_LANE_PERMIT_I <= 1'b1;
    opset(1'b1, 1'b1, 1'b1);
    st(4'h8);
    fr(8'h75, 24'h000000, 16, 0, 5'h00, 5'h04);
    fr(8'h75, 24'h000000, 8, 0, 5'h04, 5'h1F);
    st(4'h5);
    fr(8'h03, 24'h120000, 32, 0, 5'h02, 5'h1F);
    fr(8'hD8, 24'h340000, 32, 0, 5'h01, 5'h1F);
    fr(8'h02, 24'h120000, 32, 0, 5'h01, 5'h1F);
    fr(8'h02, 24'h340000, 32, 0, 5'h02, 5'h1F);
    fr(8'h32, 24'h340000, 32, 2, 5'h10, 5'h1F);
    fr(8'hB0, 24'h000000, 8, 0, 5'h01, 5'h1F);
    resume();
    st(4'h8);
    foreach (busy_ops[i]) begin
      fr(busy_ops[i], 24'h340000, 32, 0, 5'h01, 5'h1F);
    end
    opset(1'b0, 1'b0, 1'b0);
    st(4'h0);
    opset(1'b1, 1'b0, 1'b1);
    fr(8'hB0, 24'h000000, 8, 0, 5'h04, 5'h1F);
    st(4'h6);
    fr(8'h02, 24'h340000, 32, 0, 5'h01, 5'h1F);
    fr(8'h0B, 24'h340000, 32, 0, 5'h02, 5'h1F);
    fr(8'h75, 24'h000000, 8, 0, 5'h01, 5'h1F);
    resume();
    opset(1'b0, 1'b0, 1'b0);
    opset(1'b1, 1'b1, 1'b0);
    fr(8'h75, 24'h000000, 8, 0, 5'h01, 5'h1F);
    st(4'h8);
    tally_and_finish();
  end
endmodule : qps_top_test
